// ### adc_config_register_bank.sv
// Serially programmed configuration register bank of the converter section.
//
// Contract
// - Reset pin pulse returns registers to defaults.
// - Software reset bit clears all, then self-clears.
// - Every register holds zero after any reset.
// - Registers keep contents during any power-down.
// - Readback enable drives addressed register out.
// - Register 1 bit 0 fully shuts converters.
// - Per-lane output shutdown and global output disable.
// - Register 1 bits 9:2 shut channels down.
// - Register 1 bit 10 selects fast sleep.
// - Register 1 bit 14 doubles output rate.
// - Register 1 bit 15 selects single-ended clock.
// - Register 2 bit 11 averages channel pairs.
// - Register 2 bit 12 selects 8-cycle latency.
// - Register 2 bits 15:13 select test pattern.
// - Register 3 bits 7:0 invert channels.
// - Register 3 bit 8 enables offset subtraction.
// - Register 3 bit 12 enables digital gain.
// - Register 3 bits 14:13 set serializer factor.
// - Register 4 selects code format and resolution.
// - Register 4 bit 4 selects bit order.
// - Each channel has a 10-bit offset field.
// - Each channel has a 5-bit gain field.
// - Custom pattern comes from register 5 bits 13:0.
`timescale 1ns/100ps

module adc_config_register_bank (
	input  wire logic                      ref_clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic                      reset_pin_i,
	input  wire logic                      serial_clk_i,
	input  wire logic                      serial_select_n_i,
	input  wire logic                      serial_write_input_i,
	output logic                           serial_read_output_o,
	output logic                           serial_read_oe_o,
	output adc_cfg_pkg::adc_cfg_s          cfg_o,
	output adc_cfg_pkg::chan_offset_t      channel_offset_value_o,
	output adc_cfg_pkg::chan_gain_t        channel_gain_value_o
);
	import adc_cfg_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic       sclk_prev_q;
	logic       sclk_s;
	logic       sel_n_s;
	logic       serial_write_input_s;
	logic       pin_reset_s;
	logic       sclk_rise;
	logic       sclk_fall;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q     <= SYNC_IDLE;
			sync2_q     <= SYNC_IDLE;
			sclk_prev_q <= 1'b0;
		end else begin
			sync1_q     <= {reset_pin_i, serial_write_input_i,
			                serial_select_n_i, serial_clk_i};
			sync2_q     <= sync1_q;
			sclk_prev_q <= sync2_q[0];
		end
	end

	assign sclk_s      = sync2_q[0];
	assign sel_n_s     = sync2_q[1];
	assign serial_write_input_s     = sync2_q[2];
	assign pin_reset_s = sync2_q[3];
	assign sclk_rise   = sclk_s & ~sclk_prev_q;
	assign sclk_fall   = ~sclk_s & sclk_prev_q;

	// ---------------------------------------------------------------
	// Serial frame reception
	// ---------------------------------------------------------------
	logic [4:0]           bit_cnt_q;
	logic [FRAME_BITS-2:0] shift_q;
	logic                 wr_q;
	logic [ADDR_BITS-1:0] wr_addr_q;
	logic [DATA_BITS-1:0] wr_data_q;
	logic [FRAME_BITS-1:0] word;

	assign word = {shift_q, serial_write_input_s};

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_cnt_q <= 5'h00;
			shift_q   <= '0;
		end else if (sel_n_s) begin
			bit_cnt_q <= 5'h00;
		end else if (sclk_rise) begin
			shift_q <= word[FRAME_BITS-2:0];
			if (bit_cnt_q == LAST_BIT) begin
				bit_cnt_q <= 5'h00;
			end else begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q      <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= '0;
		end else begin
			wr_q <= ~sel_n_s & sclk_rise & (bit_cnt_q == LAST_BIT);
			if (~sel_n_s & sclk_rise & (bit_cnt_q == LAST_BIT)) begin
				wr_addr_q <= word[FRAME_BITS-1:DATA_BITS];
				wr_data_q <= word[DATA_BITS-1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Register storage
	// ---------------------------------------------------------------
	logic [DATA_BITS-1:0] regs_q [NUM_REGS];
	logic [DATA_BITS-1:0] chan_q [NUM_CH];
	logic                 readout_en;
	logic                 soft_reset;
	logic                 clear_all;
	logic                 wr_allowed;

	assign readout_en = regs_q[0][READOUT_BIT];
	assign soft_reset = wr_q & (wr_addr_q == ADDR_RESET_READBACK)
	                    & wr_data_q[SOFT_RESET_BIT];
	assign clear_all  = pin_reset_s | soft_reset;
	// In readout mode only the control register stays writable.
	assign wr_allowed = wr_q & (~readout_en
	                    | (wr_addr_q == ADDR_RESET_READBACK));

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_q[i] <= REG_RESET;
			end
			for (int c = 0; c < NUM_CH; c++) begin
				chan_q[c] <= REG_RESET;
			end
		end else if (clear_all) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_q[i] <= REG_RESET;
			end
			for (int c = 0; c < NUM_CH; c++) begin
				chan_q[c] <= REG_RESET;
			end
		end else if (wr_allowed) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				if (wr_addr_q == ADDR_BITS'(i)) begin
					regs_q[i] <= wr_data_q & REG_MASK[i];
				end
			end
			for (int c = 0; c < NUM_CH; c++) begin
				if (wr_addr_q == CHAN_ADDR[c]) begin
					chan_q[c] <= wr_data_q & CHAN_MASK;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Readback
	// ---------------------------------------------------------------
	logic [DATA_BITS-1:0] rd_q;
	logic [ADDR_BITS-1:0] rd_addr;
	logic [DATA_BITS-1:0] rd_word;

	assign rd_addr = word[ADDR_BITS-1:0];

	always_comb begin
		rd_word = '0;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (rd_addr == ADDR_BITS'(i)) begin
				rd_word = regs_q[i];
			end
		end
		for (int c = 0; c < NUM_CH; c++) begin
			if (rd_addr == CHAN_ADDR[c]) begin
				rd_word = chan_q[c];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_q                 <= '0;
			serial_read_output_o <= 1'b0;
		end else if (~sel_n_s & sclk_rise & (bit_cnt_q == ADDR_LAST)) begin
			rd_q <= rd_word;
		end else if (~sel_n_s & sclk_fall & (bit_cnt_q >= DATA_FIRST)) begin
			serial_read_output_o <= rd_q[DATA_BITS-1];
			rd_q                 <= {rd_q[DATA_BITS-2:0], 1'b0};
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			serial_read_oe_o <= 1'b0;
		end else begin
			serial_read_oe_o <= readout_en & ~sel_n_s;
		end
	end

	// ---------------------------------------------------------------
	// Configuration fields
	// ---------------------------------------------------------------
	always_comb begin
		cfg_o            = '0;
		cfg_o.readout_en = readout_en;
		cfg_o.converter_full_shutdown = regs_q[1][FULL_SHUT_BIT];
		cfg_o.converter_channel_shutdown =
			regs_q[1][CH_SHUT_LSB +: NUM_CH];
		cfg_o.converter_fast_sleep = regs_q[1][FAST_SLEEP_BIT];
		cfg_o.output_disable = regs_q[1][OUT_DISABLE_BIT];
		cfg_o.lane_shutdown  = regs_q[2][LANE_SHUT_LSB +: NUM_CH];
		cfg_o.noise_suppress = regs_q[1][NOISE_SUPP_BIT];
		cfg_o.outside_reference_select_a = regs_q[1][OUTSIDE_REFERENCE_SELECT_A_A_BIT];
		cfg_o.outside_reference_select_b = regs_q[3][OUTSIDE_REFERENCE_SELECT_A_B_BIT];
		cfg_o.double_rate_output = regs_q[1][DOUBLE_RATE_BIT];
		cfg_o.clock_single_ended = regs_q[1][SINGLE_CLK_BIT];
		cfg_o.averaging = regs_q[2][AVERAGE_BIT];
		cfg_o.low_latency    = regs_q[2][LOW_LAT_BIT];
		cfg_o.latency_cycles = regs_q[2][LOW_LAT_BIT] ? LATENCY_LOW
		                                              : LATENCY_DEFAULT;
		cfg_o.pattern = test_pattern_e'(regs_q[2][PATTERN_LSB +: 3]);
		cfg_o.invert = regs_q[3][INVERT_LSB +: NUM_CH];
		cfg_o.offset_subtract = regs_q[3][OFFSET_EN_BIT];
		cfg_o.gain_apply = regs_q[3][GAIN_EN_BIT];
		cfg_o.serializer_factor =
			serializer_factor_e'(regs_q[3][SER_LSB +: 2]);
		cfg_o.resolution_12b = regs_q[4][RES_12B_BIT];
		cfg_o.offset_binary  = regs_q[4][OFFSET_BIN_BIT];
		cfg_o.msb_first = regs_q[4][MSB_FIRST_BIT];
		cfg_o.custom_pattern = regs_q[5][CUSTOM_WIDTH-1:0];
	end

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			channel_offset_value_o[c] = chan_q[c][OFFSET_WIDTH-1:0];
			channel_gain_value_o[c]   = chan_q[c][GAIN_LSB +: GAIN_WIDTH];
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	soft_reset_clear_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		soft_reset |=> (regs_q[0] == REG_RESET) && (regs_q[1] == REG_RESET)
		               && (chan_q[0] == REG_RESET))
		else $error("Soft reset did not clear the registers.");

	pin_reset_clear_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		pin_reset_s |=> (regs_q[2] == REG_RESET) && (regs_q[4] == REG_RESET))
		else $error("Reset pin did not clear the registers.");

	frame_commit_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(~sel_n_s & sclk_rise & (bit_cnt_q == LAST_BIT))
		|=> wr_q && (wr_data_q == $past(word[DATA_BITS-1:0])))
		else $error("Complete word was not committed.");

	sleep_hold_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(cfg_o.converter_full_shutdown & ~wr_q & ~pin_reset_s)
		|=> $stable(regs_q[1]) && $stable(regs_q[3]))
		else $error("Register changed during power-down.");

	readout_oe_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(readout_en & ~sel_n_s) |=> serial_read_oe_o)
		else $error("Readback output not enabled.");

	readout_block_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(readout_en & wr_q & (wr_addr_q == ADDR_POWER_CLOCK) & ~pin_reset_s)
		|=> $stable(regs_q[1]))
		else $error("Write accepted during readback mode.");

	readout_shift_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(~sel_n_s & sclk_fall & (bit_cnt_q == DATA_FIRST))
		|=> serial_read_output_o == $past(rd_q[DATA_BITS-1]))
		else $error("Readback bit not shifted out.");

	offset_write_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(wr_q & ~readout_en & ~pin_reset_s & (wr_addr_q == CHAN_ADDR[0]))
		##1 ~wr_q |-> channel_offset_value_o[0] ==
		              $past(wr_data_q[OFFSET_WIDTH-1:0]))
		else $error("Channel offset not stored.");

	latency_sel_a: assert property (
		@(posedge ref_clk_i) disable iff (!rst_n_i)
		(wr_allowed & ~clear_all & (wr_addr_q == ADDR_OUTPUT_PATTERN))
		|=> cfg_o.latency_cycles == ($past(wr_data_q[LOW_LAT_BIT])
		                             ? LATENCY_LOW : LATENCY_DEFAULT))
		else $error("Latency selection mismatch.");

endmodule

// ### adc_cfg_pkg.sv
// Constants and types shared by the converter configuration register bank.
package adc_cfg_pkg;

	// ---------------------------------------------------------------
	// Serial frame layout
	// ---------------------------------------------------------------
	localparam int          FRAME_BITS = 24;
	localparam int          ADDR_BITS  = 8;
	localparam int          DATA_BITS  = 16;
	localparam logic [4:0]  LAST_BIT   = 5'h17;
	localparam logic [4:0]  ADDR_LAST  = 5'h07;
	localparam logic [4:0]  DATA_FIRST = 5'h08;

	// ---------------------------------------------------------------
	// Register addresses
	// ---------------------------------------------------------------
	localparam int         NUM_REGS = 6;
	localparam int         NUM_CH   = 8;
	localparam logic [7:0] ADDR_RESET_READBACK = 8'h00;
	localparam logic [7:0] ADDR_POWER_CLOCK    = 8'h01;
	localparam logic [7:0] ADDR_OUTPUT_PATTERN = 8'h02;
	localparam logic [7:0] ADDR_INVERT_SERIAL  = 8'h03;
	localparam logic [7:0] ADDR_RES_FORMAT     = 8'h04;
	localparam logic [7:0] ADDR_CUSTOM_PATTERN = 8'h05;
	// Channel 1 first; channels 5 to 8 count downward from the top.
	localparam logic [7:0] CHAN_ADDR [NUM_CH] = '{
		8'h0D, 8'h0F, 8'h11, 8'h13, 8'h1F, 8'h1D, 8'h1B, 8'h19};

	// ---------------------------------------------------------------
	// Writable bits of each register and reset value
	// ---------------------------------------------------------------
	localparam logic [15:0] REG_MASK [NUM_REGS] = '{
		16'h0003, 16'hEFFF, 16'hFFF8, 16'hF1FF, 16'h001A, 16'h3FFF};
	localparam logic [15:0] CHAN_MASK = 16'hFBFF;
	localparam logic [15:0] REG_RESET = 16'h0000;
	// Synchroniser reset value matches the idle pin levels.
	localparam logic [3:0]  SYNC_IDLE = 4'h2;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int SOFT_RESET_BIT   = 0;
	localparam int READOUT_BIT      = 1;
	localparam int FULL_SHUT_BIT    = 0;
	localparam int OUT_DISABLE_BIT  = 1;
	localparam int CH_SHUT_LSB      = 2;
	localparam int FAST_SLEEP_BIT   = 10;
	localparam int NOISE_SUPP_BIT   = 11;
	localparam int OUTSIDE_REFERENCE_SELECT_A_A_BIT    = 13;
	localparam int DOUBLE_RATE_BIT  = 14;
	localparam int SINGLE_CLK_BIT   = 15;
	localparam int LANE_SHUT_LSB    = 3;
	localparam int AVERAGE_BIT      = 11;
	localparam int LOW_LAT_BIT      = 12;
	localparam int PATTERN_LSB      = 13;
	localparam int INVERT_LSB       = 0;
	localparam int OFFSET_EN_BIT    = 8;
	localparam int GAIN_EN_BIT      = 12;
	localparam int SER_LSB          = 13;
	localparam int OUTSIDE_REFERENCE_SELECT_A_B_BIT    = 15;
	localparam int RES_12B_BIT      = 1;
	localparam int OFFSET_BIN_BIT   = 3;
	localparam int MSB_FIRST_BIT    = 4;
	localparam int CUSTOM_WIDTH     = 14;
	localparam int OFFSET_WIDTH     = 10;
	localparam int GAIN_LSB         = 11;
	localparam int GAIN_WIDTH       = 5;

	// Pipeline latency in converter clocks for each latency setting.
	localparam logic [3:0] LATENCY_DEFAULT = 4'hB;
	localparam logic [3:0] LATENCY_LOW     = 4'h8;

	typedef enum logic [2:0] {
		PAT_NORMAL = 3'h0, PAT_SYNC  = 3'h1, PAT_DESKEW = 3'h2,
		PAT_CUSTOM = 3'h3, PAT_ONES  = 3'h4, PAT_TOGGLE = 3'h5,
		PAT_ZEROS  = 3'h6, PAT_RAMP  = 3'h7
	} test_pattern_e;

	typedef enum logic [1:0] {
		SER_14X = 2'h0, SER_16X = 2'h1, SER_RSVD = 2'h2, SER_12X = 2'h3
	} serializer_factor_e;

	typedef logic [NUM_CH-1:0][OFFSET_WIDTH-1:0] chan_offset_t;
	typedef logic [NUM_CH-1:0][GAIN_WIDTH-1:0]   chan_gain_t;

	typedef struct packed {
		logic                    readout_en;
		logic                    converter_full_shutdown;
		logic [NUM_CH-1:0]       converter_channel_shutdown;
		logic                    converter_fast_sleep;
		logic                    output_disable;
		logic                    noise_suppress;
		logic                    outside_reference_select_a;
		logic                    outside_reference_select_b;
		logic                    double_rate_output;
		logic                    clock_single_ended;
		logic [NUM_CH-1:0]       lane_shutdown;
		logic                    averaging;
		logic                    low_latency;
		logic [3:0]              latency_cycles;
		test_pattern_e           pattern;
		logic [NUM_CH-1:0]       invert;
		logic                    offset_subtract;
		logic                    gain_apply;
		serializer_factor_e      serializer_factor;
		logic                    resolution_12b;
		logic                    offset_binary;
		logic                    msb_first;
		logic [CUSTOM_WIDTH-1:0] custom_pattern;
	} adc_cfg_s;

endpackage

// ### serial_controller_model.sv
// Behavioural model of the controller that drives the serial control port.
`timescale 1ns/100ps

module serial_controller_model #(
	parameter int HALF = 5
) (
	input  wire logic ref_clk_i,
	output logic      serial_clk_o,
	output logic      serial_select_n_o,
	output logic      serial_write_input_o,
	input  wire logic serial_read_output_i,
	input  wire logic serial_read_oe_i
);

	// ---------------------------------------------------------------
	// Idle levels
	// ---------------------------------------------------------------
	initial begin
		serial_clk_o = 1'b0;
		serial_select_n_o = 1'b1;
		serial_write_input_o = 1'b0;
	end

	// ---------------------------------------------------------------
	// Frame transfer
	// ---------------------------------------------------------------
	// address then data
	task automatic frame(input logic [7:0] addr, input logic [15:0] data,
			input int nbits, output logic [15:0] rd, output logic oe_ok);
		logic [23:0] word;
		int          i;
		word = {addr, data};
		rd = 16'h0000;
		oe_ok = 1'b1;
		@(negedge ref_clk_i);
		serial_select_n_o = 1'b0;
		repeat (HALF) @(negedge ref_clk_i);
		for (i = 0; i < nbits; i++) begin
			serial_write_input_o = word[23-i];
			repeat (HALF) @(negedge ref_clk_i);
			if (i >= 8) begin
				rd[23-i] = serial_read_output_i;
				oe_ok = oe_ok & serial_read_oe_i;
			end
			serial_clk_o = 1'b1;
			repeat (HALF) @(negedge ref_clk_i);
			serial_clk_o = 1'b0;
		end
		repeat (HALF) @(negedge ref_clk_i);
		serial_select_n_o = 1'b1;
		// The released data line must not keep its last value.
		serial_write_input_o = ~serial_write_input_o;
		repeat (2 * HALF) @(negedge ref_clk_i);
	endtask

endmodule

// ### testbench.sv
// Self-checking testbench of the converter configuration register bank.
`timescale 1ns/100ps

module testbench;
	import adc_cfg_pkg::*;

	logic         ref_clk;
	logic         rst_n;
	logic         reset_pin;
	logic         sclk;
	logic         sel_n;
	logic         sdi;
	logic         sdo;
	logic         sdo_oe;
	adc_cfg_s     cfg;
	chan_offset_t offs;
	chan_gain_t   gains;
	int           num_errors = 0;
	int           check_count = 0;
	logic [15:0]  regs [NUM_REGS];
	logic [15:0]  chans [NUM_CH];
	logic [15:0]  rd;
	logic [15:0]  wdata;
	logic         oe_ok;
	int           k;
	int           c;

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	adc_config_register_bank i_adc_config_register_bank (
		.ref_clk_i              (ref_clk),
		.rst_n_i                (rst_n),
		.reset_pin_i            (reset_pin),
		.serial_clk_i           (sclk),
		.serial_select_n_i      (sel_n),
		.serial_write_input_i   (sdi),
		.serial_read_output_o   (sdo),
		.serial_read_oe_o       (sdo_oe),
		.cfg_o                  (cfg),
		.channel_offset_value_o (offs),
		.channel_gain_value_o   (gains)
	);

	serial_controller_model i_serial_controller_model (
		.ref_clk_i            (ref_clk),
		.serial_clk_o         (sclk),
		.serial_select_n_o    (sel_n),
		.serial_write_input_o (sdi),
		.serial_read_output_i (sdo),
		.serial_read_oe_i     (sdo_oe)
	);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic check(input logic [79:0] got, input logic [79:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic clear_shadow();
		for (int i = 0; i < NUM_REGS; i++) regs[i] = 16'h0000;
		for (int i = 0; i < NUM_CH; i++) chans[i] = 16'h0000;
	endtask

	function automatic adc_cfg_s exp_cfg();
		adc_cfg_s e;
		e = '0;
		e.readout_en = regs[0][1];
		e.converter_full_shutdown = regs[1][0];
		e.converter_channel_shutdown = regs[1][9:2];
		e.converter_fast_sleep = regs[1][10];
		e.output_disable = regs[1][1];
		e.lane_shutdown = regs[2][10:3];
		e.noise_suppress = regs[1][11];
		e.outside_reference_select_a = regs[1][13];
		e.outside_reference_select_b = regs[3][15];
		e.double_rate_output = regs[1][14];
		e.clock_single_ended = regs[1][15];
		e.averaging = regs[2][11];
		e.low_latency = regs[2][12];
		e.latency_cycles = regs[2][12] ? 4'h8 : 4'hB;
		e.pattern = test_pattern_e'(regs[2][15:13]);
		e.invert = regs[3][7:0];
		e.offset_subtract = regs[3][8];
		e.gain_apply = regs[3][12];
		e.serializer_factor = serializer_factor_e'(regs[3][14:13]);
		e.resolution_12b = regs[4][1];
		e.offset_binary = regs[4][3];
		e.msb_first = regs[4][4];
		e.custom_pattern = regs[5][13:0];
		return e;
	endfunction

	task automatic chk_all();
		chan_offset_t eo;
		chan_gain_t   eg;
		for (int i = 0; i < NUM_CH; i++) begin
			eo[i] = chans[i][9:0];
			eg[i] = chans[i][15:11];
		end
		check(80'(cfg), 80'(exp_cfg()));
		check(80'(offs), 80'(eo));
		check(80'(gains), 80'(eg));
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic en;
		en = regs[0][1];
		i_serial_controller_model.frame(a, d, 24, rd, oe_ok);
		check(80'(oe_ok), 80'(en));
		if (a == 8'h00 && d[0]) clear_shadow();
		else if (a < 8'(NUM_REGS)) regs[a[2:0]] = d & REG_MASK[a[2:0]];
		for (int i = 0; i < NUM_CH; i++)
			if (CHAN_ADDR[i] == a) chans[i] = d & CHAN_MASK;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [15:0] d,
			input logic [15:0] exp);
		i_serial_controller_model.frame(a, d, 24, rd, oe_ok);
		check(80'(rd), 80'(exp));
		check(80'(oe_ok), 80'(1'b1));
	endtask

	task automatic conclude();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		reset_pin = 1'b0;
		clear_shadow();
		repeat (16) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk_all();
		for (k = 0; k < 8; k++) begin
			wdata = k[0] ? 16'hA5A5 : 16'h4A5A;
			wr(8'h01, wdata);
			wdata = {k[2:0], k[0], ~k[0], 8'h01 << k, 3'h0};
			wr(8'h02, wdata);
			wdata = {k[0], k[1:0], k[2], 3'h0, k[1], 8'h80 >> k};
			wr(8'h03, wdata);
			wdata = {11'h0, k[2], k[1], 1'b0, k[0], 1'b0};
			wr(8'h04, wdata);
			wdata = k[0] ? 16'h2AAA : 16'h1555;
			wr(8'h05, wdata);
			for (c = 0; c < NUM_CH; c++) begin
				wdata = {5'(k * 3 + c), 1'b0, 10'(k * 97 + c * 61)};
				wr(CHAN_ADDR[c], wdata);
			end
			chk_all();
		end
		// Converters are now fully shut down and in fast sleep.
		wr(8'h00, 16'h0002);
		chk_all();
		for (k = 1; k < NUM_REGS; k++)
			rdchk(8'(k), 16'hFFFF, regs[k]);
		rdchk(8'h00, 16'h0002, 16'h0002);
		rdchk(8'h07, 16'h0000, 16'h0000);
		for (c = 0; c < NUM_CH; c++)
			rdchk(CHAN_ADDR[c], 16'hFFFF, chans[c]);
		chk_all();
		i_serial_controller_model.frame(8'h00, 16'h0000, 12,
			rd, oe_ok);
		chk_all();
		wr(8'h00, 16'h0001);
		chk_all();
		wr(8'h01, 16'h0401);
		chk_all();
		wr(8'h02, 16'hFFF8);
		reset_pin = 1'b1;
		clear_shadow();
		repeat (4) @(negedge ref_clk);
		chk_all();
		reset_pin = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk_all();
		conclude();
	end

	initial begin
		repeat (60000) @(posedge ref_clk);
		num_errors++;
		$display("Watchdog expired at %0t", $time);
		conclude();
	end

endmodule
